/* design/mtpfs_pkg.sv */
// Constants, types and timing for the flash command sequencer host
package mtpfs_pkg;
  // ****************
  // Clock and timing
  // ****************
  localparam int CLK_PERIOD_NS   = 4;
  localparam int T_CE_W_NS       = 100;
  localparam int T_WP_NS         = 60;
  localparam int T_WPH_NS        = 100;
  localparam int T_DH_NS         = 10;
  localparam int T_ACC_NS        = 150;
  localparam int T_DIS_NS        = 35;
  localparam int T_VPP_NS        = 100;
  localparam int T_PROG_TOT_US   = 300;
  localparam int T_ERASE_TOT_S   = 5;
  localparam logic [7:0] CE_W_CYC = 8'((T_CE_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WPH_CYC  = 8'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DH_CYC   = 8'((T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACC_CYC  = 8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DIS_CYC  = 8'((T_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] VPP_CYC  = 8'((T_VPP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PROG_TMO_CYC  = T_PROG_TOT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ERASE_TMO_CYC = T_ERASE_TOT_S * (1000000000 / CLK_PERIOD_NS);
  // ****************
  // Opcodes and map
  // ****************
  localparam logic [7:0]  OP_IDENT     = 8'h90;
  localparam logic [7:0]  OP_ERASE     = 8'h30;
  localparam logic [7:0]  OP_PROG      = 8'h40;
  localparam logic [7:0]  OP_RESET     = 8'hFF;
  localparam logic [15:0] ID_MFR_ADDR  = 16'h0000;
  localparam logic [15:0] ID_DEV_ADDR  = 16'h0001;
  localparam logic [15:0] CMD_ADDR     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [3:0]  FTEST_NORMAL = 4'h0;
  localparam int          POLL_BIT     = 7;
  localparam int          TOGGLE_BIT   = 6;
  // ****************
  // Types
  // ****************
  typedef enum logic [2:0] {
    HOP_READ, HOP_IDENT, HOP_ERASE, HOP_PROG, HOP_ABORT
  } mtpfs_op_t;
  typedef enum logic [2:0] {
    E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_RECOV
  } mtpfs_eng_state_t;
  typedef enum logic [3:0] {
    S_IDLE, S_VPP_ON, S_CMD1, S_CMD2, S_READ_A, S_READ_B, S_POLL, S_RST1, S_RST2, S_VPP_OFF
  } mtpfs_seq_state_t;
endpackage

/* design/mtpfs_cyc_if.sv */
// One pin bus cycle request and its answer between sequencer and cycle engine
`timescale 1ns/100ps
interface mtpfs_cyc_if;
  logic        req;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

/* design/mtpfs_bus_cycle.sv */
// Pin cycle engine: one timed write or read cycle on the flash programming pins
`timescale 1ns/100ps
module mtpfs_bus_cycle (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  mtpfs_cyc_if.eng         cyc,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [15:0]      addr_o,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  input  wire logic [7:0]  data_i
);
  typedef struct packed {
    mtpfs_pkg::mtpfs_eng_state_t state;
    logic [7:0]                  cnt;
    logic                        ce_n;
    logic                        oe_n;
    logic                        we_n;
    logic [15:0]                 addr;
    logic [7:0]                  dout;
    logic                        doe;
    logic                        done;
    logic [7:0]                  rdata;
  } mtpfs_eng_t;

  mtpfs_eng_t q, d;

  // ****************
  // Cycle sequencing
  // ****************
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end
    case (q.state)
      mtpfs_pkg::E_IDLE: begin
        if (cyc.req) begin
          d.addr = cyc.addr;
          d.ce_n = 1'b0;
          if (cyc.wr) begin
            d.dout = cyc.wdata;
            d.doe = 1'b1;
            d.cnt = mtpfs_pkg::CE_W_CYC;
          end else begin
            d.oe_n = 1'b0;
            d.cnt = mtpfs_pkg::ACC_CYC;
          end
          d.state = mtpfs_pkg::E_SETUP;
        end
      end
      mtpfs_pkg::E_SETUP: begin
        if (q.cnt == 8'h00) begin
          if (q.doe) begin
            d.we_n = 1'b0;
            d.cnt = mtpfs_pkg::WP_CYC;
            d.state = mtpfs_pkg::E_STROBE;
          end else begin
            d.rdata = data_i;
            d.oe_n = 1'b1;
            d.ce_n = 1'b1;
            d.cnt = mtpfs_pkg::DIS_CYC;
            d.state = mtpfs_pkg::E_RECOV;
          end
        end
      end
      mtpfs_pkg::E_STROBE: begin
        if (q.cnt == 8'h00) begin
          // WE rises first so its edge is the latching one
          d.we_n = 1'b1;
          d.cnt = mtpfs_pkg::DH_CYC;
          d.state = mtpfs_pkg::E_HOLD;
        end
      end
      mtpfs_pkg::E_HOLD: begin
        if (q.cnt == 8'h00) begin
          d.ce_n = 1'b1;
          d.doe = 1'b0;
          d.cnt = mtpfs_pkg::WPH_CYC;
          d.state = mtpfs_pkg::E_RECOV;
        end
      end
      mtpfs_pkg::E_RECOV: begin
        if (q.cnt == 8'h00) begin
          d.done = 1'b1;
          d.state = mtpfs_pkg::E_IDLE;
        end
      end
      default: begin
        d.state = mtpfs_pkg::E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{state: mtpfs_pkg::E_IDLE, cnt: 8'h00, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
             addr: 16'h0000, dout: 8'h00, doe: 1'b0, done: 1'b0, rdata: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign cyc.done  = q.done;
  assign cyc.rdata = q.rdata;
  assign ce_n_o    = q.ce_n;
  assign oe_n_o    = q.oe_n;
  assign we_n_o    = q.we_n;
  assign addr_o    = q.addr;
  assign data_o    = q.dout;
  assign data_oe_o = q.doe;
endmodule

/* design/mtpfs_host.sv */
// Host sequencer that drives the flash command register through its programming pins
//
// Summary of operation
// - Opcode 90h puts device in ID mode; following reads give ID codes.
// - First 30h write only stages chip erase.
// - Second consecutive 30h write starts erase at WE rising edge.
// - Opcode 40h only stages byte programming.
// - Two FFh writes after a set-up abort without altering memory.
// - After a failure two FFh writes idle the device; new command follows.
// - Host sends the inverse of the byte to be stored.
// - Pins: 16-bit address, 8-bit two-way data, 4-bit test select.
`timescale 1ns/100ps
module mtpfs_host #(
  parameter int unsigned PROG_TMO_CYC  = mtpfs_pkg::PROG_TMO_CYC,
  parameter int unsigned ERASE_TMO_CYC = mtpfs_pkg::ERASE_TMO_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [2:0]  cmd_op_i,
  input  wire logic [15:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_data_i,
  output logic             cmd_ready_o,
  output logic             done_o,
  output logic             fail_o,
  output logic [15:0]      result_o,
  output logic             vpp_high_o,
  output logic [3:0]       flash_test_select_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [15:0]      program_address_lines_o,
  output logic [7:0]       program_data_lines_o,
  output logic             program_data_lines_oe_o,
  input  wire logic [7:0]  program_data_lines_i
);
  typedef struct packed {
    mtpfs_pkg::mtpfs_seq_state_t state;
    mtpfs_pkg::mtpfs_op_t        op;
    logic                        pend;
    logic                        req;
    logic                        bwr;
    logic [15:0]                 baddr;
    logic [7:0]                  bdata;
    logic [15:0]                 addr;
    logic [7:0]                  wdata;
    logic                        vpp;
    logic                        ready;
    logic                        done;
    logic                        fail;
    logic [15:0]                 result;
    logic                        prev_tog;
    logic                        have_prev;
    logic [31:0]                 tmo;
    logic [7:0]                  cnt;
    logic [3:0]                  ftest;
  } mtpfs_host_t;

  mtpfs_host_t q, d;
  mtpfs_cyc_if cyc ();

  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] setup_opcode(input mtpfs_pkg::mtpfs_op_t op);
    if (op == mtpfs_pkg::HOP_IDENT) begin
      setup_opcode = mtpfs_pkg::OP_IDENT;
    end else if (op == mtpfs_pkg::HOP_ERASE) begin
      setup_opcode = mtpfs_pkg::OP_ERASE;
    end else begin
      setup_opcode = mtpfs_pkg::OP_PROG;
    end
  endfunction

  // Only bits 7 and 6 are trusted; the rest float during status reads
  function automatic logic poll_finished(input mtpfs_pkg::mtpfs_op_t op, input logic [7:0] rd,
                                         input logic [7:0] sent, input logic prev,
                                         input logic have);
    logic steady;
    steady = have && (rd[mtpfs_pkg::TOGGLE_BIT] == prev);
    if (op == mtpfs_pkg::HOP_ERASE) begin
      poll_finished = steady && rd[mtpfs_pkg::POLL_BIT];
    end else begin
      poll_finished = steady && (rd[mtpfs_pkg::POLL_BIT:mtpfs_pkg::TOGGLE_BIT] ==
                                 sent[mtpfs_pkg::POLL_BIT:mtpfs_pkg::TOGGLE_BIT]);
    end
  endfunction

  // ****************
  // Sequencer
  // ****************
  always_comb begin
    logic        iss;
    logic        iwr;
    logic [15:0] iaddr;
    logic [7:0]  idata;
    d = q;
    iss = 1'b0;
    iwr = 1'b0;
    iaddr = mtpfs_pkg::CMD_ADDR;
    idata = mtpfs_pkg::BYTE_ZERO;
    d.req = 1'b0;
    d.done = 1'b0;
    if (q.cnt != 8'h00) begin
      d.cnt = q.cnt - 8'h01;
    end
    if (cyc.done) begin
      d.pend = 1'b0;
    end
    case (q.state)
      mtpfs_pkg::S_IDLE: begin
        d.ready = 1'b1;
        if (cmd_valid_i) begin
          d.op = mtpfs_pkg::mtpfs_op_t'(cmd_op_i);
          d.addr = cmd_addr_i;
          d.wdata = ~cmd_data_i;
          d.ready = 1'b0;
          d.fail = 1'b0;
          d.vpp = 1'b1;
          d.cnt = mtpfs_pkg::VPP_CYC;
          d.state = mtpfs_pkg::S_VPP_ON;
        end
      end
      mtpfs_pkg::S_VPP_ON: begin
        if (q.cnt == 8'h00) begin
          if (q.op == mtpfs_pkg::HOP_READ) begin
            d.state = mtpfs_pkg::S_READ_A;
          end else if (q.op == mtpfs_pkg::HOP_ABORT) begin
            d.state = mtpfs_pkg::S_RST1;
          end else begin
            d.state = mtpfs_pkg::S_CMD1;
          end
        end
      end
      mtpfs_pkg::S_CMD1: begin
        iss = 1'b1;
        iwr = 1'b1;
        idata = setup_opcode(q.op);
        if (cyc.done) begin
          d.state = (q.op == mtpfs_pkg::HOP_IDENT) ? mtpfs_pkg::S_READ_A : mtpfs_pkg::S_CMD2;
        end
      end
      mtpfs_pkg::S_CMD2: begin
        iss = 1'b1;
        iwr = 1'b1;
        if (q.op == mtpfs_pkg::HOP_ERASE) begin
          idata = mtpfs_pkg::OP_ERASE;
        end else begin
          iaddr = q.addr;
          idata = q.wdata;
        end
        if (cyc.done) begin
          // Status is only read after the second write has completed
          d.have_prev = 1'b0;
          d.tmo = (q.op == mtpfs_pkg::HOP_ERASE) ? ERASE_TMO_CYC : PROG_TMO_CYC;
          d.state = mtpfs_pkg::S_POLL;
        end
      end
      mtpfs_pkg::S_READ_A: begin
        iss = 1'b1;
        iaddr = (q.op == mtpfs_pkg::HOP_IDENT) ? mtpfs_pkg::ID_MFR_ADDR : q.addr;
        if (cyc.done) begin
          if (q.op == mtpfs_pkg::HOP_IDENT) begin
            d.result = {cyc.rdata, mtpfs_pkg::BYTE_ZERO};
            d.state = mtpfs_pkg::S_READ_B;
          end else begin
            d.result = {mtpfs_pkg::BYTE_ZERO, cyc.rdata};
            d.cnt = mtpfs_pkg::VPP_CYC;
            d.state = mtpfs_pkg::S_VPP_OFF;
          end
        end
      end
      mtpfs_pkg::S_READ_B: begin
        iss = 1'b1;
        iaddr = mtpfs_pkg::ID_DEV_ADDR;
        if (cyc.done) begin
          d.result = {q.result[15:8], cyc.rdata};
          d.cnt = mtpfs_pkg::VPP_CYC;
          d.state = mtpfs_pkg::S_VPP_OFF;
        end
      end
      mtpfs_pkg::S_POLL: begin
        iss = 1'b1;
        iaddr = q.addr;
        if (q.tmo != 32'h0000_0000) begin
          d.tmo = q.tmo - 32'h0000_0001;
        end
        if (cyc.done) begin
          d.prev_tog = cyc.rdata[mtpfs_pkg::TOGGLE_BIT];
          d.have_prev = 1'b1;
          if (poll_finished(q.op, cyc.rdata, q.wdata, q.prev_tog, q.have_prev)) begin
            d.result = {mtpfs_pkg::BYTE_ZERO, cyc.rdata};
            d.cnt = mtpfs_pkg::VPP_CYC;
            d.state = mtpfs_pkg::S_VPP_OFF;
          end else if (q.tmo == 32'h0000_0000) begin
            d.fail = 1'b1;
            d.state = mtpfs_pkg::S_RST1;
          end
        end
      end
      mtpfs_pkg::S_RST1: begin
        iss = 1'b1;
        iwr = 1'b1;
        idata = mtpfs_pkg::OP_RESET;
        if (cyc.done) begin
          d.state = mtpfs_pkg::S_RST2;
        end
      end
      mtpfs_pkg::S_RST2: begin
        iss = 1'b1;
        iwr = 1'b1;
        idata = mtpfs_pkg::OP_RESET;
        if (cyc.done) begin
          d.cnt = mtpfs_pkg::VPP_CYC;
          d.state = mtpfs_pkg::S_VPP_OFF;
        end
      end
      mtpfs_pkg::S_VPP_OFF: begin
        if (q.cnt == 8'h00) begin
          // Dropping the supply clears the command register
          d.vpp = 1'b0;
          d.done = 1'b1;
          d.state = mtpfs_pkg::S_IDLE;
        end
      end
      default: begin
        d.state = mtpfs_pkg::S_IDLE;
      end
    endcase
    // One request per cycle state, one per read in S_POLL; done of the last one must clear first
    if (iss && !q.pend && !cyc.done) begin
      d.req = 1'b1;
      d.pend = 1'b1;
      d.bwr = iwr;
      d.baddr = iaddr;
      d.bdata = idata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{state: mtpfs_pkg::S_IDLE, op: mtpfs_pkg::HOP_READ, pend: 1'b0, req: 1'b0,
             bwr: 1'b0, baddr: 16'h0000, bdata: 8'h00, addr: 16'h0000, wdata: 8'h00,
             vpp: 1'b0, ready: 1'b0, done: 1'b0, fail: 1'b0, result: 16'h0000,
             prev_tog: 1'b0, have_prev: 1'b0, tmo: 32'h0000_0000, cnt: 8'h00,
             ftest: mtpfs_pkg::FTEST_NORMAL};
    end else begin
      q <= d;
    end
  end

  assign cyc.req   = q.req;
  assign cyc.wr    = q.bwr;
  assign cyc.addr  = q.baddr;
  assign cyc.wdata = q.bdata;

  // ****************
  // Pin engine
  // ****************
  mtpfs_bus_cycle u_cycle (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .cyc       (cyc.eng),
    .ce_n_o    (ce_n_o),
    .oe_n_o    (oe_n_o),
    .we_n_o    (we_n_o),
    .addr_o    (program_address_lines_o),
    .data_o    (program_data_lines_o),
    .data_oe_o (program_data_lines_oe_o),
    .data_i    (program_data_lines_i)
  );

  assign cmd_ready_o         = q.ready;
  assign done_o              = q.done;
  assign fail_o              = q.fail;
  assign result_o            = q.result;
  assign vpp_high_o          = q.vpp;
  assign flash_test_select_o = q.ftest;
endmodule

/* bench/mtpfs_host_sva.sv */
// Pin protocol assertions for the flash command sequencer host
`timescale 1ns/100ps
module mtpfs_host_sva (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        vpp_high_o,
  input wire logic [3:0]  flash_test_select_o,
  input wire logic        ce_n_o,
  input wire logic        oe_n_o,
  input wire logic        we_n_o,
  input wire logic [15:0] program_address_lines_o,
  input wire logic [7:0]  program_data_lines_o,
  input wire logic        program_data_lines_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_ftest_normal: assert property (flash_test_select_o == mtpfs_pkg::FTEST_NORMAL)
    else $error("test select left normal mode");
  a_ce_needs_vpp: assert property ($fell(ce_n_o) |-> vpp_high_o && $past(vpp_high_o, 24))
    else $error("chip select fell without supply set-up");
  a_vpp_quiet_pins: assert property ($changed(vpp_high_o) |-> ce_n_o && oe_n_o && $past(ce_n_o))
    else $error("supply changed with strobes active");
  a_we_in_write: assert property (!we_n_o |-> !ce_n_o && oe_n_o && program_data_lines_oe_o)
    else $error("write strobe outside a write cycle");
  a_we_pulse_width: assert property ($fell(we_n_o) |-> (!we_n_o)[*8] ##1 (!we_n_o)[*7])
    else $error("write pulse too short");
  a_we_release: assert property ($fell(we_n_o) |-> ##[15:20] $rose(we_n_o))
    else $error("write pulse not ended in time");
  a_data_hold: assert property ($rose(we_n_o) |-> (program_data_lines_oe_o
    && $stable(program_data_lines_o) && $stable(program_address_lines_o))[*3])
    else $error("data or address not held after write rise");
  a_we_before_ce: assert property ($rose(ce_n_o) |-> we_n_o && $past(we_n_o))
    else $error("chip select rose before write strobe");
  a_ce_setup_write: assert property ($fell(we_n_o) |-> $past(ce_n_o, 24) == 1'b0)
    else $error("chip select set-up before write too short");
  a_no_contention: assert property (!oe_n_o |-> !program_data_lines_oe_o && we_n_o)
    else $error("host drives data during a read");
  a_done_idle: assert property (done_o |-> !vpp_high_o ##1 cmd_ready_o && !done_o)
    else $error("done without supply drop and idle");
  a_ready_quiet: assert property (cmd_ready_o |-> ce_n_o && oe_n_o && !vpp_high_o)
    else $error("pins active while idle");
endmodule
bind mtpfs_host mtpfs_host_sva u_sva (
  .clk_i                   (clk_i),
  .resetn_i                (resetn_i),
  .cmd_ready_o             (cmd_ready_o),
  .done_o                  (done_o),
  .vpp_high_o              (vpp_high_o),
  .flash_test_select_o     (flash_test_select_o),
  .ce_n_o                  (ce_n_o),
  .oe_n_o                  (oe_n_o),
  .we_n_o                  (we_n_o),
  .program_address_lines_o (program_address_lines_o),
  .program_data_lines_o    (program_data_lines_o),
  .program_data_lines_oe_o (program_data_lines_oe_o)
);

/* bench/mtpfs_flash_model.sv */
// Behavioural flash device with command register, status bits and array
`timescale 1ns/100ps
module mtpfs_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        vpp_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [31:0] busy_cyc_i,
  output logic [7:0]       data_o
);
  typedef enum logic [1:0] {M_READ, M_IDENT, M_PROG, M_ERASE} mtpfs_mode_t;
  mtpfs_mode_t mode_q = M_READ;
  logic [7:0]  stage_q = 8'h00;
  logic [7:0]  pd_q = 8'h00;
  logic [15:0] pa_q = 16'h0000;
  logic [15:0] la_q = 16'h0000;
  logic [7:0]  noise_q = 8'h5C;
  logic        tgl_q = 1'b0;
  int          busy_q = 0;
  logic        rd_q = 1'b0;
  logic [7:0]  mem_q [0:65535];
  // Array starts erased
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_q[i] = 8'hFF;
    end
  end
  // ****************
  // Command writes
  // ****************
  always @(negedge we_n_i) begin
    if (!ce_n_i) begin
      la_q = addr_i;
    end
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && vpp_i) begin
      if (stage_q == mtpfs_pkg::OP_PROG) begin
        pa_q = la_q;
        pd_q = data_i;
        busy_q = busy_cyc_i;
        mode_q = M_PROG;
        stage_q = 8'h00;
      end else if (stage_q != 8'h00) begin
        if (data_i == stage_q && stage_q == mtpfs_pkg::OP_ERASE) begin
          busy_q = busy_cyc_i;
          mode_q = M_ERASE;
        end else begin
          mode_q = M_READ;
        end
        stage_q = 8'h00;
      end else if (data_i == mtpfs_pkg::OP_IDENT) begin
        mode_q = M_IDENT;
      end else begin
        stage_q = data_i;
      end
    end
  end
  always @(negedge vpp_i) begin
    stage_q = 8'h00;
    if (mode_q == M_IDENT) begin
      mode_q = M_READ;
    end
  end
  // ****************
  // Self-timed work
  // ****************
  always @(posedge clk_i) begin
    noise_q <= ~{noise_q[6:0], noise_q[7]};
    // Read start seen on the clock, so CE and OE falling together cannot race
    rd_q <= !ce_n_i && !oe_n_i;
    if (!ce_n_i && !oe_n_i && !rd_q) begin
      tgl_q <= ~tgl_q;
    end
    if ((mode_q == M_PROG || mode_q == M_ERASE) && busy_q > 1) begin
      busy_q <= busy_q - 1;
    end else if ((mode_q == M_PROG || mode_q == M_ERASE) && busy_q == 1) begin
      busy_q <= 0;
      if (mode_q == M_PROG) begin
        mem_q[pa_q] <= pd_q;
      end else begin
        for (int i = 0; i < 65536; i++) begin
          mem_q[i] <= 8'hFF;
        end
      end
      mode_q <= M_READ;
    end
  end
  // ****************
  // Reads
  // ****************
  always @* begin
    data_o = noise_q;
    if (!ce_n_i && !oe_n_i) begin
      case (mode_q)
        M_IDENT: data_o = (addr_i == mtpfs_pkg::ID_MFR_ADDR) ? MFR_CODE :
                          (addr_i == mtpfs_pkg::ID_DEV_ADDR) ? DEV_CODE : noise_q;
        M_PROG:  data_o = {~pd_q[7], tgl_q, noise_q[5:0]};
        M_ERASE: data_o = {1'b0, tgl_q, noise_q[5:0]};
        default: data_o = mem_q[addr_i];
      endcase
    end
  end
endmodule

/* bench/testbench.sv */
// Self-checking bench: host sequencer against a behavioural flash device
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0]  MFR  = 8'hA7; // Arbitrary value
  localparam logic [7:0]  DEV  = 8'h4E; // Arbitrary value
  localparam logic [16:0] FULL = 17'h1FFFF;
  logic        clk_i;
  logic        resetn_i;
  logic        cmd_valid_i;
  logic [2:0]  cmd_op_i;
  logic [15:0] cmd_addr_i;
  logic [7:0]  cmd_data_i;
  logic        cmd_ready_o;
  logic        done_o;
  logic        fail_o;
  logic [15:0] result_o;
  logic        vpp_high_o;
  logic [3:0]  ftest;
  logic        ce_n_o;
  logic        oe_n_o;
  logic        we_n_o;
  logic [15:0] pa_o;
  logic [7:0]  pd_o;
  logic        pd_oe;
  logic [7:0]  dev_dq;
  logic [7:0]  dq;
  int          busy_cyc;
  int          error_cnt;
  int          checks_done;
  logic [31:0] rng_q;
  logic [15:0] a;
  logic [7:0]  d;
  logic [16:0] e;
  logic [16:0] m;
  logic [16:0] exp_q[$];
  logic [16:0] msk_q[$];
  assign dq = pd_oe ? pd_o : dev_dq;
  mtpfs_host #(.PROG_TMO_CYC(200), .ERASE_TMO_CYC(2000)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .fail_o(fail_o), .result_o(result_o), .vpp_high_o(vpp_high_o),
    .flash_test_select_o(ftest), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .program_address_lines_o(pa_o), .program_data_lines_o(pd_o),
    .program_data_lines_oe_o(pd_oe), .program_data_lines_i(dq));
  mtpfs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (
    .clk_i(clk_i), .vpp_i(vpp_high_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .addr_i(pa_o), .data_i(dq), .busy_cyc_i(busy_cyc), .data_o(dev_dq));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] xs();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction
  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic run_cmd(input mtpfs_pkg::mtpfs_op_t op, input logic [15:0] ad,
                         input logic [7:0] dt, input logic [16:0] ex, input logic [16:0] mk);
    int n;
    @(posedge clk_i);
    #1;
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    cmd_valid_i = 1'b1;
    cmd_op_i = op;
    cmd_addr_i = ad;
    cmd_data_i = dt;
    // Ready seen off the edge is what the next edge samples
    while (cmd_ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1 cmd_valid_i = 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (done_o !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  // ****************
  // Result monitor
  // ****************
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      check("pending notes", 17'(exp_q.size()), 17'h00001);
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check("fail and result", {fail_o, result_o} & m, e & m);
    end
  end
  // ****************
  // Stimulus
  // ****************
  initial begin
    resetn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = 3'h0;
    cmd_addr_i = 16'h0000;
    cmd_data_i = 8'h00;
    busy_cyc = 1;
    error_cnt = 0;
    checks_done = 0;
    rng_q = 32'h0000226A;
    repeat (16) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    run_cmd(mtpfs_pkg::HOP_IDENT, 16'h0000, 8'h00, {1'b0, MFR, DEV}, FULL);
    for (int i = 0; i < 4; i++) begin
      rng_q = xs();
      a = rng_q[15:0];
      d = rng_q[23:16];
      busy_cyc = (i == 0) ? 1 : 60 + i * 30;
      run_cmd(mtpfs_pkg::HOP_PROG, a, d, {9'h000, ~d}, FULL);
      run_cmd(mtpfs_pkg::HOP_READ, a, 8'h00, {9'h000, ~d}, FULL);
    end
    run_cmd(mtpfs_pkg::HOP_ABORT, 16'h0000, 8'h00, {9'h000, ~d}, FULL);
    run_cmd(mtpfs_pkg::HOP_READ, a, 8'h00, {9'h000, ~d}, FULL);
    busy_cyc = 600;
    run_cmd(mtpfs_pkg::HOP_ERASE, a, 8'h00, {9'h000, 8'hFF}, FULL);
    run_cmd(mtpfs_pkg::HOP_READ, a, 8'h00, {9'h000, 8'hFF}, FULL);
    busy_cyc = 0;
    run_cmd(mtpfs_pkg::HOP_PROG, 16'h7FFE, 8'h0F, 17'h10000, 17'h10000);
    busy_cyc = 1;
    run_cmd(mtpfs_pkg::HOP_READ, 16'h7FFE, 8'h00, {9'h000, 8'hFF}, FULL);
    run_cmd(mtpfs_pkg::HOP_IDENT, 16'h0000, 8'h00, {1'b0, MFR, DEV}, FULL);
    @(posedge clk_i);
    #1 check("notes left", 17'(exp_q.size()), 17'h00000);
    print_verdict();
  end
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule
